// *** rtl/event_oneshot_counter_timer.sv ***
// Contract
// - Timer mode: underflow toggles output pin
// - Enable cleared forces output pin low, except a running one-shot
// - Event mode counts pin edge or overflow
// - Event mode direction follows direction bit
// - Six triggers: pin or overflow edges
// - Underflow: reload if auto, else FFFFh; timer mode always reloads
// - Overflow: reload if auto, else 0000h
// - Event counting only while enabled
// - Event mode interrupts on over/underflow
// - Event pulse output toggles on wrap
// - Count readback is the live counter
// - Reset loads reload when counting down; else 0000h
// - Re-enable resumes held value unless reset
// - After reset: reload down, zero up
// - One-shot starts at reload, counts down
// - One-shot needs enable; enable or overflow
// - One-shot clears enable one tick later
// - One-shot halts at underflow, ignores auto
// - One-shot in event mode: overflow ticks
// - One-shot interrupts on underflow
// - One-shot pulse: high start, low stop
`timescale 1ns/1ps
module event_oneshot_counter_timer
   import oneshot_event_timer_pkg::*;
(
   input wire logic CLK, // System clock, 125 MHz
   input wire logic RESETN, // Asynchronous reset, active low
   input wire logic TIMER_TICK, // Timer clock tick, one cycle
   input wire logic TIMER_INPUT_PIN, // External event input
   input wire logic PREV_OVERFLOW, // Preceding timer overflow
   input wire ctrl_t CTRL, // Firmware control settings
   input wire logic ONESHOT_EVENT, // One-shot combined with event
   input wire logic RELOAD_WE, // Reload write strobe
   input wire logic [15:0] RELOAD_WDATA, // Reload write data
   output logic TIMER_OUTPUT_PIN, // Timer output pin
   output logic TIMER_IRQ, // Interrupt pulse to controller
   output logic ENABLE_STATUS, // Current enable control
   output logic [15:0] COUNT_VALUE, // Live counter value
   output logic [15:0] RELOAD_VALUE, // Reload register readback
   output logic OVERFLOW_OUT // Overflow to next timer
);

   state_t r; // Registered state
   state_t next_r; // Next state
   logic ovf_q; // Registered overflow for next timer

   // Edge match for selected event source
   function automatic logic edge_hit(input logic now, input logic was, input logic [1:0] sel);
      logic rise;
      logic fall;
      rise = now & ~was;
      fall = ~now & was;
      unique case (sel)
         EDGE_RISE: edge_hit = rise;
         EDGE_FALL: edge_hit = fall;
         EDGE_BOTH: edge_hit = rise | fall;
         default: edge_hit = 1'b0; // Illegal code ignored
      endcase
   endfunction : edge_hit

   logic pin_evt; // Input pin edge seen
   logic prev_evt; // Overflow input edge seen
   logic prev_rise; // Overflow input rising edge
   logic evt_tick; // Selected event
   logic step; // Counter advances this cycle
   logic up; // Counting direction
   logic wrap_lo; // Underflow about to occur
   logic wrap_hi; // Overflow about to occur
   logic is_event; // Event mode flag
   logic is_oneshot; // One-shot mode flag

   // Event decode and direction
   always_comb
   begin
      pin_evt = edge_hit(TIMER_INPUT_PIN, r.pin_q, CTRL.edge_sel);
      prev_evt = edge_hit(PREV_OVERFLOW, r.prev_q, CTRL.edge_sel);
      prev_rise = PREV_OVERFLOW & ~r.prev_q;
      evt_tick = (CTRL.event_src == EVT_SRC_PREV) ? prev_evt : pin_evt;
      is_event = (CTRL.mode == MODE_EVENT);
      is_oneshot = (CTRL.mode == MODE_ONESHOT);
      up = is_event & CTRL.count_direction_bit;
      if (is_event)
      begin
         step = r.enable & evt_tick;
      end
      else if (is_oneshot)
      begin
         step = (r.os_state == OS_RUN) & (ONESHOT_EVENT ? prev_rise : TIMER_TICK);
      end
      else
      begin
         step = r.enable & TIMER_TICK;
      end
      wrap_lo = step & ~up & (r.count == CNT_ZERO);
      wrap_hi = step & up & (r.count == CNT_MAX);
   end

   // Next state
   always_comb
   begin
      next_r = r;
      next_r.pin_q = TIMER_INPUT_PIN;
      next_r.prev_q = PREV_OVERFLOW;
      next_r.irq = 1'b0;
      // Firmware reload write
      if (RELOAD_WE)
      begin
         next_r.reload = RELOAD_WDATA;
      end
      // Firmware enable control; hardware auto-clear below wins
      if (CTRL.enable_set)
      begin
         next_r.enable = 1'b1;
      end
      else if (CTRL.enable_clr)
      begin
         next_r.enable = 1'b0;
      end
      if (CTRL.timer_reset)
      begin
         // Reset event: restart point depends on direction
         next_r.count = up ? CNT_ZERO : r.reload;
         next_r.os_state = OS_IDLE;
         next_r.os_clear_pend = 1'b0;
         next_r.out_pin = 1'b0;
      end
      else if (is_oneshot)
      begin
         unique case (r.os_state)
            OS_IDLE:
            begin
               if (r.enable)
               begin
                  next_r.os_state = OS_ARMED;
               end
            end
            OS_ARMED:
            begin
               // Start on enable or on overflow from previous timer
               if (!r.enable)
               begin
                  next_r.os_state = OS_IDLE;
               end
               else if (CTRL.start_src == START_ON_ENABLE || prev_rise)
               begin
                  next_r.count = r.reload;
                  next_r.os_state = OS_RUN;
                  next_r.os_clear_pend = 1'b1;
                  next_r.out_pin = CTRL.pulse_en;
               end
            end
            OS_RUN:
            begin
               // Clear enable one tick after start
               if (r.os_clear_pend && TIMER_TICK)
               begin
                  next_r.enable = 1'b0;
                  next_r.os_clear_pend = 1'b0;
               end
               if (wrap_lo)
               begin
                  // Halt, auto-reload ignored
                  next_r.os_state = OS_IDLE;
                  next_r.irq = 1'b1;
                  next_r.out_pin = 1'b0;
                  next_r.enable = 1'b0;
                  next_r.os_clear_pend = 1'b0;
               end
               else if (step)
               begin
                  next_r.count = r.count - 16'h0001;
               end
            end
            default:
            begin
               next_r.os_state = OS_IDLE; // Unused code recovers
            end
         endcase
      end
      else if (step)
      begin
         // Timer and event mode counting; held value resumes when re-enabled
         if (wrap_lo)
         begin
            next_r.count = (CTRL.auto_reload_bit || !is_event) ? r.reload : CNT_MAX;
            next_r.irq = is_event;
            next_r.out_pin = is_event ? (r.out_pin ^ CTRL.pulse_en) : ~r.out_pin;
         end
         else if (wrap_hi)
         begin
            next_r.count = CTRL.auto_reload_bit ? r.reload : CNT_ZERO;
            next_r.irq = 1'b1;
            next_r.out_pin = r.out_pin ^ CTRL.pulse_en;
         end
         else
         begin
            next_r.count = up ? r.count + 16'h0001 : r.count - 16'h0001;
         end
      end
      // Output forced low while disabled, except a running one-shot
      if (!next_r.enable && !(is_oneshot && next_r.os_state == OS_RUN))
      begin
         next_r.out_pin = 1'b0;
      end
   end

   // State register
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         r <= '0;
         r.reload <= CNT_MAX;
         r.count <= CNT_MAX;
         ovf_q <= 1'b0;
      end
      else
      begin
         r <= next_r;
         ovf_q <= wrap_lo | wrap_hi;
      end
   end

   // Registered outputs
   always_comb
   begin
      TIMER_OUTPUT_PIN = r.out_pin;
      TIMER_IRQ = r.irq;
      ENABLE_STATUS = r.enable;
      COUNT_VALUE = r.count;
      RELOAD_VALUE = r.reload;
      OVERFLOW_OUT = ovf_q;
   end

endmodule : event_oneshot_counter_timer

// *** rtl/oneshot_event_timer_pkg.sv ***
package oneshot_event_timer_pkg;

   // Counter width
   localparam int CNT_W = 16;
   // Wrap values
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   // Operating modes
   typedef enum logic [1:0]
   {
      MODE_TIMER = 2'h0,
      MODE_EVENT = 2'h1,
      MODE_ONESHOT = 2'h2,
      MODE_RSVD = 2'h3
   } mode_t;

   // Edge selection codes
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;

   // Event source codes
   localparam logic EVT_SRC_PIN = 1'h0;
   localparam logic EVT_SRC_PREV = 1'h1;

   // One-shot start source codes
   localparam logic START_ON_ENABLE = 1'h0;
   localparam logic START_ON_PREV = 1'h1;

   // One-shot sequence states; each step flips one bit except RUN back to IDLE
   typedef enum logic [1:0]
   {
      OS_IDLE = 2'b00,
      OS_ARMED = 2'b01,
      OS_RUN = 2'b11
   } os_state_t;

   // Control settings from firmware
   typedef struct packed
   {
      logic enable_set;
      logic enable_clr;
      logic timer_reset;
      mode_t mode;
      logic count_direction_bit;
      logic auto_reload_bit;
      logic event_src;
      logic [1:0] edge_sel;
      logic start_src;
      logic pulse_en;
   } ctrl_t;

   // Full block state
   typedef struct packed
   {
      logic enable;
      logic [15:0] count;
      logic [15:0] reload;
      logic pin_q;
      logic prev_q;
      logic out_pin;
      logic irq;
      logic os_clear_pend;
      os_state_t os_state;
   } state_t;

endpackage : oneshot_event_timer_pkg

// *** test/event_oneshot_counter_timer_bench.sv ***
`timescale 1ns/1ps
module event_oneshot_counter_timer_bench;
   import oneshot_event_timer_pkg::*;
   logic clk = 1'b0; // Clock
   logic resetn = 1'b0; // Reset
   logic tick = 1'b0; // Timer tick
   logic [1:0] div = 2'h0; // Tick divider
   logic oe = 1'b0; // One-shot tick source
   logic we = 1'b0; // Reload strobe
   logic [15:0] wdata = 16'h0000; // Reload data
   ctrl_t ctl = '0; // Controls
   wire logic pin, prev, tout, irq, en, ovf; // Pins
   wire logic [15:0] cnt, rld; // Readbacks
   int num_errors = 0; // Mismatches
   int check_count = 0; // Comparisons
   int irq_n = 0; // Interrupts seen
   int n0; // Interrupt mark
   logic [15:0] held; // Halted count
   event_oneshot_counter_timer u_event_oneshot_counter_timer (.CLK(clk), .RESETN(resetn), .TIMER_TICK(tick),
      .TIMER_INPUT_PIN(pin), .PREV_OVERFLOW(prev), .CTRL(ctl), .ONESHOT_EVENT(oe), .RELOAD_WE(we),
      .RELOAD_WDATA(wdata), .TIMER_OUTPUT_PIN(tout), .TIMER_IRQ(irq), .ENABLE_STATUS(en),
      .COUNT_VALUE(cnt), .RELOAD_VALUE(rld), .OVERFLOW_OUT(ovf));
   event_source_model u_event_source_model (.CLK(clk), .PIN(pin), .PREV(prev));
   // Clock
   always #4 clk = ~clk;
   // Tick every fourth cycle, interrupt tally
   always @(posedge clk)
   begin
      div <= div + 2'h1;
      tick <= div == 2'h3;
      if (irq === 1'b1)
         irq_n <= irq_n + 1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic complete_run;
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %0t exp %h got %h", $time, exp, got);
      end
   endtask : cmp
   // Write reload, then pulse timer reset
   task automatic load(input logic [15:0] v);
      we <= 1'b1;
      wdata <= v;
      cyc(1);
      we <= 1'b0;
      ctl.timer_reset <= 1'b1;
      cyc(1);
      ctl.timer_reset <= 1'b0;
      cyc(2);
   endtask : load
   // Pulse set or clear of enable
   task automatic set_en(input logic on);
      ctl.enable_set <= on;
      ctl.enable_clr <= !on;
      cyc(1);
      ctl.enable_set <= 1'b0;
      ctl.enable_clr <= 1'b0;
      cyc(2);
   endtask : set_en
   // Bounded wait for output pin level
   task automatic wait_pin(input logic v);
      for (int i = 0; i < 100 && tout !== v; i++)
         cyc(1);
      cmp({15'h0, v}, {15'h0, tout});
   endtask : wait_pin
   // Main sequence
   initial
   begin
      cyc(3);
      resetn <= 1'b1;
      cyc(1);
      ctl.mode <= MODE_EVENT;
      ctl.pulse_en <= 1'b1;
      load(16'h0001);
      cmp(16'h0001, cnt);
      set_en(1'b1);
      u_event_source_model.burst(1'b0, 2);
      cyc(3);
      cmp(CNT_MAX, cnt);
      cmp(16'h0001, irq_n[15:0]);
      cmp(16'h0001, {15'h0, tout});
      ctl.count_direction_bit <= 1'b1;
      ctl.auto_reload_bit <= 1'b1;
      u_event_source_model.burst(1'b0, 1);
      cyc(3);
      cmp(16'h0001, cnt);
      cmp(16'h0000, {15'h0, tout});
      set_en(1'b0);
      u_event_source_model.burst(1'b0, 2);
      cyc(3);
      cmp(16'h0001, cnt);
      set_en(1'b1);
      u_event_source_model.burst(1'b0, 1);
      cyc(3);
      cmp(16'h0002, cnt);
      ctl.count_direction_bit <= 1'b0;
      for (int k = 0; k < 6; k++)
      begin
         ctl.event_src <= k >= 3;
         ctl.edge_sel <= 2'(k % 3);
         load(16'h0010);
         u_event_source_model.burst(k >= 3, 2);
         cyc(3);
         cmp(k % 3 == 2 ? 16'h000C : 16'h000E, cnt);
      end
      ctl.count_direction_bit <= 1'b1;
      load(16'h0010);
      cmp(CNT_ZERO, cnt);
      set_en(1'b0);
      ctl.mode <= MODE_TIMER;
      load(16'h0002);
      set_en(1'b1);
      wait_pin(1'b1);
      wait_pin(1'b0);
      wait_pin(1'b1);
      set_en(1'b0);
      cmp(16'h0000, {15'h0, tout});
      ctl.mode <= MODE_ONESHOT;
      load(16'h0003);
      for (int i = 0; i < 2; i++)
      begin
         n0 = irq_n;
         ctl.start_src <= i[0];
         oe <= i[0];
         set_en(1'b1);
         cyc(1);
         cmp({15'h0, !i[0]}, {15'h0, tout});
         if (i == 1)
            u_event_source_model.burst(1'b1, 8);
         wait_pin(1'b0);
         held = cnt;
         cyc(20);
         cmp(held, cnt);
         cmp(16'h0000, {15'h0, en});
         cmp(16'(n0 + 1), irq_n[15:0]);
      end
      complete_run();
   end
endmodule : event_oneshot_counter_timer_bench

// *** test/event_oneshot_counter_timer_sva.sv ***
`timescale 1ns/1ps
module event_oneshot_counter_timer_sva
   import oneshot_event_timer_pkg::*;
(
   input wire logic CLK, // Clock
   input wire logic RESETN, // Reset
   input wire logic TIMER_TICK, // Tick
   input wire logic TIMER_INPUT_PIN, // Pin
   input wire logic PREV_OVERFLOW, // Prior wrap
   input wire ctrl_t CTRL, // Controls
   input wire logic ONESHOT_EVENT, // Tick source
   input wire logic RELOAD_WE, // Strobe
   input wire logic [15:0] RELOAD_WDATA, // Data
   input wire logic TIMER_OUTPUT_PIN, // Output
   input wire logic TIMER_IRQ, // Interrupt
   input wire logic ENABLE_STATUS, // Enable
   input wire logic [15:0] COUNT_VALUE, // Count
   input wire logic [15:0] RELOAD_VALUE, // Reload
   input wire logic OVERFLOW_OUT // Wrap out
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // Mode and direction shorthands
   wire logic evt = CTRL.mode == MODE_EVENT;
   wire logic os = CTRL.mode == MODE_ONESHOT;
   wire logic up = CTRL.count_direction_bit;
   AST_IRQ_ONE:
      assert property (TIMER_IRQ |=> !TIMER_IRQ) else $error("irq too long");
   AST_OFF_LOW:
      assert property (!os && !ENABLE_STATUS |=> !TIMER_OUTPUT_PIN) else $error("pin high while off");
   AST_HOLD:
      assert property (evt && !ENABLE_STATUS && !CTRL.enable_set && !CTRL.timer_reset |=> $stable(COUNT_VALUE))
      else $error("count moved while off");
   AST_RST_LOAD:
      assert property (CTRL.timer_reset && !RELOAD_WE && !(evt && up) |=> COUNT_VALUE == RELOAD_VALUE)
      else $error("reset did not load");
   AST_RST_UP:
      assert property (CTRL.timer_reset && evt && up |=> COUNT_VALUE == CNT_ZERO) else $error("reset up not zero");
   AST_RLD_WR:
      assert property (RELOAD_WE |=> RELOAD_VALUE == $past(RELOAD_WDATA)) else $error("reload not written");
   AST_STEP:
      assert property (evt && ENABLE_STATUS && !CTRL.timer_reset |=> TIMER_IRQ || $stable(COUNT_VALUE)
         || COUNT_VALUE == $past(COUNT_VALUE) + ($past(up) ? 16'h0001 : 16'hFFFF)) else $error("bad step");
   AST_WRAP:
      assert property (TIMER_IRQ && evt |-> COUNT_VALUE == (CTRL.auto_reload_bit ? RELOAD_VALUE
         : up ? CNT_ZERO : CNT_MAX)) else $error("bad wrap value");
   AST_OS_STOP:
      assert property (TIMER_IRQ && os |-> !TIMER_OUTPUT_PIN && !ENABLE_STATUS ##1 $stable(COUNT_VALUE))
      else $error("one-shot did not halt");
   AST_OVF_IRQ:
      assert property (TIMER_IRQ |-> OVERFLOW_OUT) else $error("wrap not passed on");
   // Main scenarios
   C_EVT_WRAP: cover property (TIMER_IRQ && evt);
   C_OS_IRQ: cover property (TIMER_IRQ && os);
   C_TOGGLE: cover property ($rose(TIMER_OUTPUT_PIN) && CTRL.mode == MODE_TIMER);
endmodule : event_oneshot_counter_timer_sva
bind event_oneshot_counter_timer event_oneshot_counter_timer_sva u_event_oneshot_counter_timer_sva (.CLK,
   .RESETN, .TIMER_TICK, .TIMER_INPUT_PIN, .PREV_OVERFLOW, .CTRL, .ONESHOT_EVENT, .RELOAD_WE, .RELOAD_WDATA,
   .TIMER_OUTPUT_PIN, .TIMER_IRQ, .ENABLE_STATUS, .COUNT_VALUE, .RELOAD_VALUE, .OVERFLOW_OUT);

// *** test/event_source_model.sv ***
`timescale 1ns/1ps
module event_source_model (
   input wire logic CLK, // Bench clock
   output logic PIN, // Event input
   output logic PREV // Prior timer wrap
);
   // Both lines idle low
   initial
   begin
      PIN = 1'b0;
      PREV = 1'b0;
   end
   // Burst of n pulses, two cycles high, two low
   task automatic burst(input logic sel, input int n);
      for (int i = 0; i < 2 * n; i++)
      begin
         if (sel)
            PREV <= ~PREV;
         else
            PIN <= ~PIN;
         repeat (2) @(posedge CLK);
      end
   endtask : burst
endmodule : event_source_model
